//--- pkg/ptu_pkg.sv
// Shared constants and carriers for the proximity/touch decision block
package ptu_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_FLAGS     = 8'h12;
  localparam logic [7:0] OFF_CH0_CFG   = 8'h40;
  localparam logic [7:0] OFF_CH1_CFG   = 8'h41;
  localparam logic [7:0] OFF_SHR_CFG   = 8'h42;
  localparam logic [7:0] OFF_CH0_TUNE  = 8'h43;
  localparam logic [7:0] OFF_CH1_TUNE  = 8'h44;
  localparam logic [7:0] OFF_EXTRA_CFG = 8'h45;
  localparam logic [7:0] OFF_CH0_NEAR  = 8'h50;
  localparam logic [7:0] OFF_CH0_CONT  = 8'h51;
  localparam logic [7:0] OFF_CH1_NEAR  = 8'h52;
  localparam logic [7:0] OFF_CH1_CONT  = 8'h53;

  // ==========================================================
  // Field positions
  localparam int FLG_CH0_NEAR = 0;
  localparam int FLG_CH1_NEAR = 1;
  localparam int FLG_CH0_CONT = 4;
  localparam int FLG_CH1_CONT = 5;
  localparam int CFG_ACTIVE   = 0;
  localparam int CFG_INDUCT   = 1;
  localparam int CFG_RX0      = 2;
  localparam int CFG_RX1      = 3;
  localparam int CFG_TX       = 4;
  localparam int SHR_CSDIV    = 0;
  localparam int SHR_UIOFF    = 1;
  localparam int EXT_ACFILT   = 0;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_CH_CFG    = 8'h05;
  localparam logic [7:0] RST_SHR_CFG   = 8'h00;
  localparam logic [7:0] RST_TUNE      = 8'h00;
  localparam logic [7:0] RST_EXTRA_CFG = 8'h01;
  localparam logic [7:0] RST_NEAR      = 8'h0a;
  localparam logic [7:0] RST_CONT      = 8'h20;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;
  localparam logic [7:0] LEVEL_MIN     = 8'h01;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [15:0] count;
    logic [15:0] longTermAverage;
  } ptu_sample_t;

  typedef struct packed {
    logic [7:0] chanCfg0;
    logic [7:0] chanCfg1;
    logic [7:0] sharedCfg;
    logic [7:0] tuneCfg0;
    logic [7:0] tuneCfg1;
    logic [7:0] extraCfg;
  } ptu_front_cfg_t;

  // ==========================================================
  // Arithmetic
  function automatic logic [15:0] ptu_deviation(input logic [15:0] a,
                                                input logic [15:0] b);
    ptu_deviation = (a > b) ? (a - b) : (b - a);
  endfunction

  // Zero is outside the legal 1..255 range; treat it as most sensitive
  function automatic logic [7:0] ptu_level(input logic [7:0] x);
    ptu_level = (x == 8'h00) ? LEVEL_MIN : x;
  endfunction

endpackage

//--- core/ptu_channel_judge.sv
// One channel's proximity and touch decision
`timescale 1ns/10ps
`default_nettype none
module ptu_channel_judge
  import ptu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire ptu_sample_t sample,
  input  wire logic [7:0]  nearLevel,
  input  wire logic [7:0]  contactLevel,
  input  wire logic        enable,
  output logic             nearHit,
  output logic             contactHit
);

  // ==========================================================
  // Thresholds
  logic [15:0] dev;
  logic [23:0] product;
  logic [15:0] contactThr;
  logic        nearHit_ff;
  logic        contactHit_ff;
  logic        nxt_nearHit;
  logic        nxt_contactHit;

  assign dev = ptu_deviation(sample.count, sample.longTermAverage);
  assign product = {16'h0000, ptu_level(contactLevel)}
                   * {8'h00, sample.longTermAverage};
  assign contactThr = product[23:8];

  // ==========================================================
  // Decision
  always_comb
  begin
    nxt_nearHit    = nearHit_ff;
    nxt_contactHit = contactHit_ff;
    if (!enable)
    begin
      nxt_nearHit    = 1'b0;
      nxt_contactHit = 1'b0;
    end
    else if (sample.valid)
    begin
      nxt_nearHit    = dev > {8'h00, ptu_level(nearLevel)};
      nxt_contactHit = dev > contactThr;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nearHit_ff    <= 1'b0;
      contactHit_ff <= 1'b0;
    end
    else
    begin
      nearHit_ff    <= nxt_nearHit;
      contactHit_ff <= nxt_contactHit;
    end
  end

  assign nearHit    = nearHit_ff;
  assign contactHit = contactHit_ff;

  // ==========================================================
  // Checks
  a_near_set: assert property (@(posedge clk) disable iff (!rst_n)
    enable && sample.valid && dev > {8'h00, ptu_level(nearLevel)}
    |=> nearHit_ff)
    else $error("proximity flag not set above threshold");

  a_near_clear: assert property (@(posedge clk) disable iff (!rst_n)
    enable && sample.valid && dev <= {8'h00, ptu_level(nearLevel)}
    |=> !nearHit_ff)
    else $error("proximity flag set at or below threshold");

  a_touch_set: assert property (@(posedge clk) disable iff (!rst_n)
    enable && sample.valid
    && {8'h00, dev} * 24'd256
       > {16'h0000, ptu_level(contactLevel)} * {8'h00, sample.longTermAverage}
       + 24'd255
    |=> contactHit_ff)
    else $error("touch flag not set above fractional threshold");

  a_touch_clear: assert property (@(posedge clk) disable iff (!rst_n)
    enable && sample.valid && dev <= contactThr |=> !contactHit_ff)
    else $error("touch flag set at or below threshold");

  a_off_clears: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !nearHit_ff && !contactHit_ff)
    else $error("flags not cleared while channel is off");

  a_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
    enable && !sample.valid && $past(enable)
    |=> $stable(nearHit_ff) && $stable(contactHit_ff))
    else $error("flags changed without a sample");

endmodule
`default_nettype wire

//--- core/ptu_top.sv
// Proximity/touch decision with its settings and flags registers
//
// How it works
// - A per-channel proximity threshold of 1 to 255 counts is compared against the channel's deviation from its long-term average.
// - Each channel's touch threshold is the programmed value over 256 times its long-term average.
// - Results read back as one read-only byte: bits 0/1 proximity and bits 4/5 touch of channels 0/1.
// - Channel 0 and channel 1 touch thresholds are kept apart at offsets 0x51 and 0x53.
// - Channel 0 and channel 1 proximity thresholds sit at offsets 0x50 and 0x52.
// - Each channel has a configuration byte choosing its sensing mode and its electrodes.
// - A shared settings byte holds the sample-capacitor divider, advised on in inductive mode.
// - A second shared byte holds the AC filter option, advised on for capacitive sensing.
// - In inductive mode the proximity/touch decision cannot be switched off by the shared settings byte, only by the channel's active bit.
`timescale 1ns/10ps
`default_nettype none
module ptu_top
  import ptu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire ptu_sample_t sample0,
  input  wire ptu_sample_t sample1,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output logic [7:0]       regRdData,
  output logic             regRdValid,
  output ptu_front_cfg_t   frontCfg
);

  // ==========================================================
  // Settings registers
  logic [7:0] chanCfg0_ff;
  logic [7:0] chanCfg1_ff;
  logic [7:0] sharedCfg_ff;
  logic [7:0] tuneCfg0_ff;
  logic [7:0] tuneCfg1_ff;
  logic [7:0] extraCfg_ff;
  logic [7:0] near0_ff;
  logic [7:0] cont0_ff;
  logic [7:0] near1_ff;
  logic [7:0] cont1_ff;
  logic [7:0] nxt_chanCfg0;
  logic [7:0] nxt_chanCfg1;
  logic [7:0] nxt_sharedCfg;
  logic [7:0] nxt_tuneCfg0;
  logic [7:0] nxt_tuneCfg1;
  logic [7:0] nxt_extraCfg;
  logic [7:0] nxt_near0;
  logic [7:0] nxt_cont0;
  logic [7:0] nxt_near1;
  logic [7:0] nxt_cont1;

  always_comb
  begin
    nxt_chanCfg0  = chanCfg0_ff;
    nxt_chanCfg1  = chanCfg1_ff;
    nxt_sharedCfg = sharedCfg_ff;
    nxt_tuneCfg0  = tuneCfg0_ff;
    nxt_tuneCfg1  = tuneCfg1_ff;
    nxt_extraCfg  = extraCfg_ff;
    nxt_near0     = near0_ff;
    nxt_cont0     = cont0_ff;
    nxt_near1     = near1_ff;
    nxt_cont1     = cont1_ff;
    // Flags and unmapped offsets take no write
    if (regWrEn)
    begin
      unique case (regAddr)
        OFF_CH0_CFG:   nxt_chanCfg0  = regWrData;
        OFF_CH1_CFG:   nxt_chanCfg1  = regWrData;
        OFF_SHR_CFG:   nxt_sharedCfg = regWrData;
        OFF_CH0_TUNE:  nxt_tuneCfg0  = regWrData;
        OFF_CH1_TUNE:  nxt_tuneCfg1  = regWrData;
        OFF_EXTRA_CFG: nxt_extraCfg  = regWrData;
        OFF_CH0_NEAR:  nxt_near0     = regWrData;
        OFF_CH1_NEAR:  nxt_near1     = regWrData;
        OFF_CH0_CONT:  nxt_cont0     = regWrData;
        OFF_CH1_CONT:  nxt_cont1     = regWrData;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chanCfg0_ff  <= RST_CH_CFG;
      chanCfg1_ff  <= RST_CH_CFG;
      sharedCfg_ff <= RST_SHR_CFG;
      tuneCfg0_ff  <= RST_TUNE;
      tuneCfg1_ff  <= RST_TUNE;
      extraCfg_ff  <= RST_EXTRA_CFG;
      near0_ff     <= RST_NEAR;
      cont0_ff     <= RST_CONT;
      near1_ff     <= RST_NEAR;
      cont1_ff     <= RST_CONT;
    end
    else
    begin
      chanCfg0_ff  <= nxt_chanCfg0;
      chanCfg1_ff  <= nxt_chanCfg1;
      sharedCfg_ff <= nxt_sharedCfg;
      tuneCfg0_ff  <= nxt_tuneCfg0;
      tuneCfg1_ff  <= nxt_tuneCfg1;
      extraCfg_ff  <= nxt_extraCfg;
      near0_ff     <= nxt_near0;
      cont0_ff     <= nxt_cont0;
      near1_ff     <= nxt_near1;
      cont1_ff     <= nxt_cont1;
    end
  end

  // The front end takes its settings straight from the registers
  assign frontCfg = '{chanCfg0:  chanCfg0_ff,  chanCfg1: chanCfg1_ff,
                      sharedCfg: sharedCfg_ff, tuneCfg0: tuneCfg0_ff,
                      tuneCfg1:  tuneCfg1_ff,  extraCfg: extraCfg_ff};

  // ==========================================================
  // Decision channels
  logic en0;
  logic en1;
  logic near0Hit;
  logic near1Hit;
  logic cont0Hit;
  logic cont1Hit;

  assign en0 = chanCfg0_ff[CFG_ACTIVE]
               && (!sharedCfg_ff[SHR_UIOFF] || chanCfg0_ff[CFG_INDUCT]);
  assign en1 = chanCfg1_ff[CFG_ACTIVE]
               && (!sharedCfg_ff[SHR_UIOFF] || chanCfg1_ff[CFG_INDUCT]);

  ptu_channel_judge uJudge0 (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample       (sample0),
    .nearLevel    (near0_ff),
    .contactLevel (cont0_ff),
    .enable       (en0),
    .nearHit      (near0Hit),
    .contactHit   (cont0Hit)
  );

  ptu_channel_judge uJudge1 (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample       (sample1),
    .nearLevel    (near1_ff),
    .contactLevel (cont1_ff),
    .enable       (en1),
    .nearHit      (near1Hit),
    .contactHit   (cont1Hit)
  );

  // ==========================================================
  // Flags byte and read path
  logic [7:0] flags;
  logic [7:0] rdData_ff;
  logic       rdValid_ff;
  logic [7:0] nxt_rdData;
  logic       nxt_rdValid;

  always_comb
  begin
    flags = 8'h00;
    flags[FLG_CH0_NEAR] = near0Hit;
    flags[FLG_CH1_NEAR] = near1Hit;
    flags[FLG_CH0_CONT] = cont0Hit;
    flags[FLG_CH1_CONT] = cont1Hit;
  end

  always_comb
  begin
    nxt_rdValid = regRdEn;
    nxt_rdData  = RD_UNMAPPED;
    if (regRdEn)
    begin
      unique case (regAddr)
        OFF_FLAGS:     nxt_rdData = flags;
        OFF_CH0_CFG:   nxt_rdData = chanCfg0_ff;
        OFF_CH1_CFG:   nxt_rdData = chanCfg1_ff;
        OFF_SHR_CFG:   nxt_rdData = sharedCfg_ff;
        OFF_CH0_TUNE:  nxt_rdData = tuneCfg0_ff;
        OFF_CH1_TUNE:  nxt_rdData = tuneCfg1_ff;
        OFF_EXTRA_CFG: nxt_rdData = extraCfg_ff;
        OFF_CH0_NEAR:  nxt_rdData = near0_ff;
        OFF_CH0_CONT:  nxt_rdData = cont0_ff;
        OFF_CH1_NEAR:  nxt_rdData = near1_ff;
        OFF_CH1_CONT:  nxt_rdData = cont1_ff;
        default:       nxt_rdData = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_ff  <= RD_UNMAPPED;
      rdValid_ff <= 1'b0;
    end
    else
    begin
      rdData_ff  <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  assign regRdData  = rdData_ff;
  assign regRdValid = rdValid_ff;

  // ==========================================================
  // Checks
  a_flags_spare: assert property (@(posedge clk) disable iff (!rst_n)
    regRdEn && regAddr == OFF_FLAGS
    |=> rdValid_ff && rdData_ff[7:6] == 2'b00 && rdData_ff[3:2] == 2'b00)
    else $error("spare flag bits not zero");

  a_flags_map: assert property (@(posedge clk) disable iff (!rst_n)
    regRdEn && regAddr == OFF_FLAGS
    |=> rdData_ff[5:4] == $past({cont1Hit, cont0Hit})
        && rdData_ff[1:0] == $past({near1Hit, near0Hit}))
    else $error("flags byte does not match channel results");

  a_near_write: assert property (@(posedge clk) disable iff (!rst_n)
    regWrEn && regAddr == OFF_CH1_NEAR
    |=> near1_ff == $past(regWrData) && near0_ff == $past(near0_ff))
    else $error("channel 1 proximity level not written alone");

  a_touch_write: assert property (@(posedge clk) disable iff (!rst_n)
    regWrEn && regAddr == OFF_CH0_CONT
    |=> cont0_ff == $past(regWrData) && cont1_ff == $past(cont1_ff))
    else $error("channel 0 touch level not written alone");

  a_flags_ro: assert property (@(posedge clk) disable iff (!rst_n)
    regWrEn && regAddr == OFF_FLAGS |=> $stable(frontCfg))
    else $error("write to flags changed settings");

  a_induct_on: assert property (@(posedge clk) disable iff (!rst_n)
    chanCfg0_ff[CFG_ACTIVE] && chanCfg0_ff[CFG_INDUCT]
    && sharedCfg_ff[SHR_UIOFF] && sample0.valid
    && ptu_deviation(sample0.count, sample0.longTermAverage)
       > {8'h00, ptu_level(near0_ff)}
    |=> near0Hit)
    else $error("inductive channel decision was disabled");

  a_read_turn: assert property (@(posedge clk) disable iff (!rst_n)
    regRdEn && regAddr == OFF_CH0_CFG ##1 !regRdEn
    |-> rdValid_ff && rdData_ff == $past(chanCfg0_ff) ##1 !rdValid_ff)
    else $error("read answer not one cycle wide");

endmodule
`default_nettype wire

//--- tb/ptu_host_model.sv
// Host side model: register master that sets up channels and polls flags
`timescale 1ns/10ps
`default_nettype none
module ptu_host_model
  import ptu_pkg::*;
(
  input  wire logic       clk,
  output logic [7:0]      regAddr,
  output logic            regWrEn,
  output logic [7:0]      regWrData,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  initial
  begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end

  // ==========================================================
  // Bus cycles, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(posedge clk);
    #1;
    regWrEn   = 1'b0;
    // Released lines change, so stale values cannot pass for data
    regAddr   = ~a;
    regWrData = ~d;
    // One idle edge, so the next call never re-raises a strobe in this step
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
    v       = regRdValid;
    @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // Setup sequences
  // target above base
  task automatic tune(input int ch, input logic [3:0] base,
                      input logic [3:0] target);
    if (target > base)
      wr((ch != 0) ? OFF_CH1_TUNE : OFF_CH0_TUNE, {target, base});
  endtask

  task automatic setupInductive(input int ch);
    wr((ch != 0) ? OFF_CH1_CFG : OFF_CH0_CFG, 8'h0f);
    wr((ch != 0) ? OFF_CH0_CFG : OFF_CH1_CFG, 8'h00);
    wr(OFF_SHR_CFG, 8'h03);
  endtask
endmodule
`default_nettype wire

//--- tb/test_prox_touch_threshold_ui.sv
// Self-checking bench for the proximity/touch decision block
`timescale 1ns/10ps
`default_nettype none
module test_prox_touch_threshold_ui
  import ptu_pkg::*;
;
  localparam logic [7:0] OFFS [10] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
                                       8'h45, 8'h50, 8'h51, 8'h52, 8'h53};
  logic           clk;
  logic           rst_n;
  ptu_sample_t    sample0;
  ptu_sample_t    sample1;
  logic [7:0]     regAddr;
  logic           regWrEn;
  logic [7:0]     regWrData;
  logic           regRdEn;
  logic [7:0]     regRdData;
  logic           regRdValid;
  ptu_front_cfg_t frontCfg;
  int             failCount;
  int             checks;
  int             cycles;
  logic [7:0]     expFlags;

  ptu_top i_dut (.clk(clk), .rst_n(rst_n), .sample0(sample0),
    .sample1(sample1), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .frontCfg(frontCfg));

  ptu_host_model i_host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid));

  // ==========================================================
  // Clock and hang guard
  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failCount++;
      endOfTest();
    end
  end

  // ==========================================================
  // Checking helpers
  task automatic chk(input string what, input logic [47:0] seen,
                     input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic readChk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.rd(a, d, v);
    chk({what, " valid"}, {47'h0, v}, 48'h1);
    chk(what, {40'h0, d}, {40'h0, exp});
  endtask

  task automatic endOfTest();
    $display("checks %0d, mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bit 1 touch, bit 0 proximity; strictly greater than the level
  function automatic logic [1:0] judge(input logic [15:0] cnt, long_term_average,
                                       input logic [7:0] nl, cl);
    logic [15:0] dev;
    logic [23:0] thr;
    dev   = (cnt > long_term_average) ? cnt - long_term_average : long_term_average - cnt;
    thr   = ({16'h0, cl} * {8'h0, long_term_average}) >> 8;
    judge = {({8'h0, dev} > thr), (dev > {8'h0, nl})};
  endfunction

  task automatic pulse(input int ch, input logic [15:0] cnt, long_term_average);
    ptu_sample_t s;
    s = '{valid: 1'b1, count: cnt, longTermAverage: long_term_average};
    if (ch == 0)
      sample0 = s;
    else
      sample1 = s;
    @(posedge clk);
    #1;
    s = '{valid: 1'b0, count: ~cnt, longTermAverage: ~long_term_average};
    if (ch == 0)
      sample0 = s;
    else
      sample1 = s;
  endtask

  task automatic trial(input int ch, input logic [15:0] cnt, long_term_average,
                       input logic [7:0] nl, cl);
    logic [1:0] j;
    i_host.wr((ch != 0) ? OFF_CH1_NEAR : OFF_CH0_NEAR, nl);
    i_host.wr((ch != 0) ? OFF_CH1_CONT : OFF_CH0_CONT, cl);
    pulse(ch, cnt, long_term_average);
    j = judge(cnt, long_term_average, nl, cl);
    expFlags[ch]     = j[0];
    expFlags[ch + 4] = j[1];
    readChk("flags", OFF_FLAGS, expFlags);
  endtask

  // ==========================================================
  // Scenarios
  task automatic testReset();
    chk("front cfg", frontCfg, {RST_CH_CFG, RST_CH_CFG, RST_SHR_CFG,
        RST_TUNE, RST_TUNE, RST_EXTRA_CFG});
    for (int i = 6; i < 10; i++)
      readChk("level", OFFS[i], OFFS[i][0] ? RST_CONT : RST_NEAR);
    readChk("flags", OFF_FLAGS, 8'h00);
    @(posedge clk);
    #1;
    chk("idle valid", {47'h0, regRdValid}, 48'h0);
    $display("test reset done");
  endtask

  task automatic testDecide();
    trial(0, 16'd100, 16'd150, 8'h0a, 8'h20);
    trial(0, 16'd286, 16'd256, 8'h1e, 8'h20);
    trial(0, 16'd287, 16'd256, 8'h1e, 8'h20);
    trial(0, 16'd223, 16'd256, 8'h1e, 8'h20);
    trial(1, 16'd1255, 16'd1000, 8'hff, 8'hff);
    trial(1, 16'd1256, 16'd1000, 8'hff, 8'hff);
    trial(1, 16'd1001, 16'd1000, 8'h01, 8'h01);
    trial(1, 16'd1002, 16'd1000, 8'h01, 8'h01);
    trial(1, 16'd300, 16'd200, 8'h0a, 8'h20);
    $display("test decide done");
  endtask

  task automatic testInductive();
    i_host.tune(0, 4'h3, 4'h9);
    i_host.setupInductive(0);
    expFlags[1] = 1'b0;
    expFlags[5] = 1'b0;
    // decision stays on with proximity below touch
    trial(0, 16'd260, 16'd200, 8'h05, 8'h40);
    i_host.wr(OFF_CH1_CFG, 8'h05);
    pulse(1, 16'd300, 16'd200);
    readChk("flags off", OFF_FLAGS, expFlags);
    i_host.wr(OFF_SHR_CFG, 8'h01);
    trial(1, 16'd300, 16'd200, 8'h0a, 8'h20);
    $display("test inductive done");
  endtask

  task automatic testRegs();
    for (int i = 0; i < 10; i++)
      i_host.wr(OFFS[i], OFFS[i] ^ 8'h5a);
    // Channel 0 config 0x1a has its active bit clear, so its flags drop
    expFlags[FLG_CH0_NEAR] = 1'b0;
    expFlags[FLG_CH0_CONT] = 1'b0;
    for (int i = 0; i < 10; i++)
      readChk("setting", OFFS[i], OFFS[i] ^ 8'h5a);
    chk("front cfg", frontCfg, {8'h1a, 8'h1b, 8'h18, 8'h19, 8'h1e,
        8'h1f});
    i_host.wr(OFF_FLAGS, 8'hff);
    readChk("flags ro", OFF_FLAGS, expFlags);
    readChk("unmapped", 8'h30, RD_UNMAPPED);
    $display("test regs done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    clk       = 1'b0;
    rst_n     = 1'b0;
    sample0   = '0;
    sample1   = '0;
    failCount = 0;
    checks    = 0;
    cycles    = 0;
    expFlags  = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    testReset();
    testDecide();
    testInductive();
    testRegs();
    endOfTest();
  end
endmodule
`default_nettype wire
